// ==== core/pcm_serial_port.sv ====
// Behaviour
// RULE1: IDL: one tx and rx word, same slot
// RULE2: Partner frames every 125 us, 8 kHz
// RULE3: IDL sync sampled on clock falling edge
// RULE4: IDL rx bit captured on falling edge
// RULE5: IDL tx drives bits from rising edges
// RULE6: IDL tx floats at slot-ending falling edge
// RULE7: GCI: one tx and rx word, same slot
// RULE8: Partner issues GCI frames at 8 kHz
// RULE9: GCI sync sampled on clock falling edge
// RULE10: GCI first bit on rising edge after sync
// RULE11: GCI clock high at sync: drive at once
// RULE12: GCI later bits on rising edges
// RULE13: GCI floats on second falling edge in LSB
// RULE14: GCI rx bits sampled on rising edge
// RULE15: Sign bit set positive, cleared negative
// RULE16: Invert seven magnitude bits, not the sign
// RULE17: Static input picks slot, both directions
// RULE18: Sign, chord, step; sign sent first
`timescale 1ns/10ps
`default_nettype none
module pcm_serial_port (
    input  wire logic                      clk_sys_i,
    input  wire logic                      arst_n_i,
    input  wire pcm_port_pkg::frame_mode_t mode_i,
    input  wire pcm_port_pkg::slot_sel_t   slot_i,
    input  wire pcm_port_pkg::link_in_t    link_i,
    input  wire pcm_port_pkg::pcm_word_t   tx_word_i,
    output logic                           tx_take_o,
    output pcm_port_pkg::pcm_word_t        rx_word_o,
    output logic                           rx_valid_o,
    output pcm_port_pkg::link_out_t        link_o
);
    import pcm_port_pkg::*;

    // **********************************************
    // Input synchronisers and edge detection
    // **********************************************
    link_in_t    meta_r;
    link_in_t    sync_r;
    link_in_t    prev_r;
    logic        rise_clk;
    logic        fall_clk;
    logic        rise_fs;
    logic        gci_md;
    logic [4:0]  bit_cnt_r;
    logic        active_r;
    logic        armed_r;
    logic        half_r;
    logic [7:0]  tx_sh_r;
    logic [7:0]  rx_sh_r;
    logic [4:0]  slot_base;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= link_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign rise_clk  = sync_r.clk & ~prev_r.clk;
    assign fall_clk  = ~sync_r.clk & prev_r.clk;
    assign rise_fs   = sync_r.sync & ~prev_r.sync;
    assign gci_md    = (mode_i == MODE_GCI);
    // Both directions share one slot base
    assign slot_base = (slot_i == SLOT_B2) ? 5'(SLOT_B2_START) : 5'h00; // [RULE17]

    // **********************************************
    // Frame start and bit position
    // **********************************************
    // Frame start found when sync is high at a falling edge; IDL bits end
    // at each falling edge, GCI bits span two clock periods
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_r <= 5'h1F;
            active_r  <= 1'b0;
            half_r    <= 1'b0;
        end else if (fall_clk && sync_r.sync) begin
            bit_cnt_r <= 5'h00; // [RULE3] [RULE9]
            active_r  <= 1'b1;
            half_r    <= gci_md;
        end else if (fall_clk && active_r) begin
            if (gci_md && !half_r) begin
                half_r <= 1'b1;
            end else if (bit_cnt_r == 5'h1F) begin
                active_r <= 1'b0;
            end else begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
                half_r    <= 1'b0;
            end
        end
    end

    // GCI: sync rising arms output; first bit driven at the next clock rise
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            armed_r <= 1'b0;
        end else if (rise_fs && gci_md) begin
            armed_r <= 1'b1;
        end else if (!sync_r.sync && fall_clk) begin
            armed_r <= 1'b0;
        end
    end

    // **********************************************
    // Transmit path
    // **********************************************
    logic [4:0] rel;
    logic       in_slot;
    assign rel     = bit_cnt_r - slot_base;
    assign in_slot = active_r && (bit_cnt_r >= slot_base)
                     && (rel < 5'(WORD_BITS)); // [RULE1] [RULE7]

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            link_o     <= '0;
            tx_sh_r    <= '0;
            tx_take_o  <= 1'b0;
        end else begin
            tx_take_o <= 1'b0;
            if (!gci_md) begin
                // IDL: bit n launched at rising edge inside bit period n
                if (rise_clk && in_slot) begin
                    if (rel == 5'h00) begin
                        // Load inverted magnitude, sign first on the line
                        tx_sh_r   <= {tx_word_i} ^ MAG_INVERT_MASK; // [RULE16] [RULE18]
                        link_o.data <= tx_word_i.sign; // [RULE15]
                        tx_take_o <= 1'b1;
                    end else begin
                        link_o.data <= tx_sh_r[SIGN_POS - rel[2:0]];
                    end
                    link_o.oe <= 1'b1; // [RULE5]
                end else if (fall_clk && link_o.oe && !sync_r.sync
                             && (bit_cnt_r == slot_base + 5'(WORD_BITS - 1))) begin
                    link_o.oe <= 1'b0; // [RULE6]
                end
            end else begin
                // GCI B1 first bit: from sync rise when clock is high
                if (rise_fs && slot_i == SLOT_B1 && sync_r.clk) begin
                    tx_sh_r     <= {tx_word_i} ^ MAG_INVERT_MASK; // [RULE11] [RULE16]
                    link_o.data <= tx_word_i.sign;
                    link_o.oe   <= 1'b1;
                    tx_take_o   <= 1'b1;
                end else if (rise_clk && armed_r && slot_i == SLOT_B1 && !link_o.oe) begin
                    tx_sh_r     <= {tx_word_i} ^ MAG_INVERT_MASK; // [RULE10] [RULE18]
                    link_o.data <= tx_word_i.sign;
                    link_o.oe   <= 1'b1;
                    tx_take_o   <= 1'b1;
                end else if (rise_clk && in_slot && !half_r) begin
                    // First rise of a bit period; B1 bit 0 already left at sync rise or the first clock rise after it
                    if (slot_i == SLOT_B2 && rel == 5'h00 && !link_o.oe) begin
                        tx_sh_r     <= {tx_word_i} ^ MAG_INVERT_MASK; // [RULE10]
                        link_o.data <= tx_word_i.sign;
                        link_o.oe   <= 1'b1;
                        tx_take_o   <= 1'b1;
                    end else if (rel != 5'h00) begin
                        link_o.data <= tx_sh_r[SIGN_POS - rel[2:0]]; // [RULE12]
                    end
                end
                // LSB period: float at its second falling edge
                if (fall_clk && link_o.oe && in_slot && half_r
                    && (rel == 5'(WORD_BITS - 1))) begin
                    link_o.oe <= 1'b0; // [RULE13]
                end
            end
        end
    end

    // **********************************************
    // Receive path
    // **********************************************
    // Sample edge differs by mode: IDL falling, GCI rising
    logic smp;
    assign smp = gci_md ? rise_clk : fall_clk;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_sh_r    <= '0;
            rx_word_o  <= RX_WORD_RST;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            // GCI takes one rise per bit, the one after its first fall
            if (smp && in_slot && (!gci_md || half_r)
                && !(fall_clk && sync_r.sync)) begin // [RULE4] [RULE14]
                rx_sh_r <= {rx_sh_r[6:0], sync_r.rx};
                if (rel == 5'(WORD_BITS - 1)) begin
                    rx_word_o  <= {rx_sh_r[6:0], sync_r.rx} ^ MAG_INVERT_MASK; // [RULE16]
                    rx_valid_o <= 1'b1;
                end
            end
        end
    end

    // **********************************************
    // Checks
    // **********************************************
    idl_float_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $fell(link_o.oe) && !gci_md |-> $past(fall_clk)) // [RULE6]
        else $error("IDL output floated off a falling edge");
    idl_drive_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(link_o.oe) && !gci_md |-> $past(rise_clk)) // [RULE5]
        else $error("IDL output driven off a rising edge");
    gci_float_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $fell(link_o.oe) && gci_md |-> $past(fall_clk)) // [RULE13]
        else $error("GCI output floated off a falling edge");
    gci_lsb_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $fell(link_o.oe) && gci_md |-> $past(half_r && rel == 5'(WORD_BITS - 1))) // [RULE13]
        else $error("GCI output floated outside second LSB fall");
    gci_drive_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(link_o.oe) && gci_md |-> $past(rise_clk || rise_fs)) // [RULE10] [RULE11]
        else $error("GCI output driven off an edge");
    frame_start_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        fall_clk && sync_r.sync |=> bit_cnt_r == 5'h00 && active_r) // [RULE3] [RULE9]
        else $error("Frame start missed");
    sign_first_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        tx_take_o |-> link_o.data == $past(tx_word_i.sign)) // [RULE15] [RULE18]
        else $error("Sign bit not sent first");
    rx_invert_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        rx_valid_o |-> rx_word_o[SIGN_POS] == $past(rx_sh_r[6])) // [RULE16]
        else $error("Received sign bit altered");
    rx_edge_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        rx_valid_o |-> $past(gci_md ? rise_clk : fall_clk)) // [RULE4] [RULE14]
        else $error("Receive bit taken on wrong edge");
    one_word_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        rx_valid_o |=> !rx_valid_o) // [RULE1] [RULE7]
        else $error("Receive word repeated");
    cv_idl_c: cover property (@(posedge clk_sys_i) rx_valid_o && !gci_md);
    cv_gci_c: cover property (@(posedge clk_sys_i) rx_valid_o && gci_md);
    cv_b2_c:  cover property (@(posedge clk_sys_i) tx_take_o && slot_i == SLOT_B2);
    cv_early_c: cover property (@(posedge clk_sys_i) rise_fs && gci_md && sync_r.clk);
endmodule
`default_nettype wire

// ==== include/pcm_port_pkg.sv ====
package pcm_port_pkg;
    // **********************************************
    // Framing, word layout and coding
    // **********************************************
    localparam int unsigned WORD_BITS       = 8;
    localparam int unsigned SLOT_B2_START   = 8;
    localparam int unsigned SIGN_POS        = 7;
    localparam int unsigned CHORD_LSB       = 4;
    localparam int unsigned CHORD_BITS      = 3;
    localparam int unsigned STEP_BITS       = 4;
    localparam logic [7:0]  MAG_INVERT_MASK = 8'h7F;
    localparam logic [7:0]  RX_WORD_RST     = 8'hFF;
    localparam real         FRAME_TIME_US   = 125.0;
    localparam real         CLK_SYS_MHZ     = 20.0;
    localparam int unsigned FRAME_CYCLES    = int'(FRAME_TIME_US * CLK_SYS_MHZ);

    typedef enum logic {MODE_IDL, MODE_GCI} frame_mode_t;
    typedef enum logic {SLOT_B1, SLOT_B2} slot_sel_t;

    typedef struct packed {
        logic       sign;
        logic [2:0] chord;
        logic [3:0] step;
    } pcm_word_t;

    typedef struct packed {
        logic clk;
        logic sync;
        logic rx;
    } link_in_t;

    typedef struct packed {
        logic data;
        logic oe;
    } link_out_t;
endpackage

// ==== tb/pcm_link_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcm_link_partner (
    output var pcm_port_pkg::link_in_t  link_o,
    input  wire pcm_port_pkg::link_out_t link_i
);
    import pcm_port_pkg::*;

    initial link_o = '0;

    // Slot bits from the word, a toggling pattern elsewhere
    function automatic logic wire_bit(int n, int base, logic [7:0] w);
        return (n >= base && n < base + 8) ? w[7 - (n - base)] : n[0];
    endfunction

    // ****************************************
    // Frame master, clock idles low between frames
    // ****************************************
    task automatic frame(input logic gci, input logic b2, input logic early,
                         input logic [7:0] rxw, output logic [7:0] txw, output int oe_bad);
        int       cpb;
        int       base;
        int       n;
        realtime  t0;
        t0 = $realtime;
        cpb = gci ? 2 : 1;
        base = b2 ? 8 : 0;
        txw = 8'h00;
        oe_bad = 0;
        // Clock already high at sync rise
        if (gci && early) begin
            link_o.clk = 1'b1;
            #100;
        end
        link_o.sync = 1'b1;
        if (gci) begin
            link_o.rx = wire_bit(0, base, rxw);
            #200;
        end else begin
            link_o.clk = 1'b1;
            #200;
            link_o.clk = 1'b0;
            #100;
            link_o.sync = 1'b0;
            #100;
        end
        for (int k = 0; k < 18 * cpb; k++) begin
            n = k / cpb;
            link_o.clk = 1'b1;
            #100;
            if (!gci) link_o.rx = wire_bit(n, base, rxw);
            #100;
            link_o.clk = 1'b0;
            #100;
            if (k == 0) link_o.sync = 1'b0;
            if (k % cpb == cpb - 1) begin
                if (n >= base && n < base + 8) begin
                    txw[7 - (n - base)] = link_i.data;
                    oe_bad += int'(link_i.oe !== 1'b1);
                end else begin
                    oe_bad += int'(link_i.oe !== 1'b0);
                end
                // Change only after the last fall, clear of both sampling edges
                if (gci) link_o.rx = wire_bit(n + 1, base, rxw);
            end
            #100;
        end
        link_o.rx = ~link_o.rx;
        #(FRAME_TIME_US * 1000.0 - ($realtime - t0));
    endtask
endmodule
`default_nettype wire

// ==== tb/tb_pcm_serial_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_pcm_serial_port;
    import pcm_port_pkg::*;

    logic        clk_sys = 1'b0;
    logic        arst_n;
    frame_mode_t mode;
    slot_sel_t   slot;
    link_in_t    link_in;
    pcm_word_t   tx_word;
    logic        tx_take;
    pcm_word_t   rx_word;
    logic        rx_valid;
    link_out_t   link_out;
    int          failures = 0;
    int          comparisons = 0;
    int          takes;
    int          valids;
    logic [7:0]  exp_q[$];

    always #25 clk_sys = ~clk_sys;

    pcm_serial_port uut (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .mode_i(mode),
        .slot_i(slot), .link_i(link_in), .tx_word_i(tx_word), .tx_take_o(tx_take),
        .rx_word_o(rx_word), .rx_valid_o(rx_valid), .link_o(link_out));

    pcm_link_partner partner (.link_o(link_in), .link_i(link_out));

    // ****************************************
    // Compare and closing tasks
    // ****************************************
    task automatic cmp8(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmpn(string what, int exp, int got);
        comparisons++;
        if (got != exp) begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Sampled mid-cycle, clear of the launching edge
    always @(negedge clk_sys) begin
        if (tx_take === 1'b1) takes++;
        if (rx_valid === 1'b1) begin
            valids++;
            cmp8("rx_word", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, rx_word);
        end
    end

    // ****************************************
    // One frame: model expectations from the wire coding
    // ****************************************
    task automatic run(logic gci, logic b2, logic early, logic [7:0] w_tx, logic [7:0] w_rx);
        logic [7:0] seen;
        int         bad;
        @(negedge clk_sys);
        mode = frame_mode_t'(gci);
        slot = slot_sel_t'(b2);
        tx_word = w_tx;
        exp_q.push_back(w_rx);
        takes = 0;
        valids = 0;
        partner.frame(gci, b2, early, {w_rx[7], ~w_rx[6:0]}, seen, bad);
        cmp8("tx_wire", {w_tx[7], ~w_tx[6:0]}, seen);
        cmpn("oe_errors", 0, bad);
        cmpn("tx_takes", 1, takes);
        cmpn("rx_valids", 1, valids);
        $display("test mode %0d slot %0d early %0d tx %h rx %h done", gci, b2, early, w_tx, w_rx);
    endtask

    initial begin
        arst_n = 1'b0;
        mode = MODE_IDL;
        slot = SLOT_B1;
        tx_word = '0;
        void'($urandom(61474));
        repeat (3) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        cmp8("rx_word_reset", RX_WORD_RST, rx_word);
        // Boundary words first, then random ones
        for (int i = 0; i < 16; i++) begin
            run(i[0], i[1], i[2], (i < 4) ? 8'h7F : 8'($urandom),
                (i < 4) ? 8'h80 : 8'($urandom));
        end
        test_done();
    end

    initial begin
        #2500000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
